// ===== include/fslr_pkg.sv
// Package for the flash security lockout recovery block
package fslr_pkg;
    localparam int DIV_W = 7;
    localparam int IR_W = 4;
    localparam int DR_W = 32;
    localparam int IDCODE_W = 32;
    // Instruction codes; values are arbitrary
    localparam logic [3:0] IR_EXTEST = 4'h0;
    localparam logic [3:0] IR_IDCODE = 4'h2;
    localparam logic [3:0] IR_DEBUG = 4'h7;
    localparam logic [3:0] IR_RECOVER = 4'h8;
    localparam logic [3:0] IR_BYPASS = 4'hF;
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    // Identity value is arbitrary
    localparam logic [31:0] IDCODE_VAL = 32'h0A5A_5001;
    // Unlock word and its location
    localparam logic [15:0] UNLOCK_WORD = 16'h0000;
    localparam logic [15:0] UNLOCK_ADDR = 16'h7FF7;
    localparam logic [6:0] DIV_RST = 7'h00;
    localparam int ERASE_TICKS = 4096;
    typedef enum logic [3:0] {
        TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR,
        TS_PAU_DR, TS_EX2_DR, TS_UPD_DR, TS_SEL_IR, TS_CAP_IR, TS_SH_IR,
        TS_EX1_IR, TS_PAU_IR, TS_EX2_IR, TS_UPD_IR
    } fslr_tap_type;
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } fslr_jtag_in_type;
    typedef struct packed {
        logic req;
        logic [15:0] addr;
        logic [15:0] data;
    } fslr_prog_type;
endpackage

// ===== src/fslr_sync.sv
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/10ps
`default_nettype none
module fslr_sync #(
    parameter int W = 3
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= d;
            q_reg <= meta_reg;
        end
    end
    assign q = q_reg;
endmodule
`default_nettype wire

// ===== src/fslr_top.sv
// TAP, flash security gate and lockout recovery sequencer
// Functional notes
// - While secured, debug-port access to flash is refused.
// - The TAP is active from boot with boundary scan and ID access.
// - Recovery erases all flash and protection; release waits for reset.
// - The host then shifts a 7-bit divider, captured on update.
// - Entry to Run-Test/Idle starts the erase.
// - Nothing is reset after erase; power-on resets both TAP and device.
// - An all-zero word at the unlock location is an unsecure request.
`timescale 1ns/10ps
`default_nettype none
module fslr_top
    import fslr_pkg::*;
#(
    parameter int ERASE_TICKS_P = ERASE_TICKS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // JTAG pins
    input wire fslr_jtag_in_type jtag_in,
    input wire logic trstn,
    output logic tdo,
    output logic tdo_oe,
    // Security strap and flash program port
    input wire logic secure_strap,
    input wire fslr_prog_type prog,
    // Debug port request and flash controls
    input wire logic dbg_flash_req,
    output logic dbg_flash_grant,
    output logic flash_erase_busy,
    output logic flash_erase_clk_en,
    output logic flash_erase_done,
    output logic secure,
    output logic debug_sel,
    output logic bscan_sel
);
    fslr_jtag_in_type js;
    logic tck_d_reg, tck_d_next;
    logic tck_rise, tck_fall;
    fslr_tap_type tap_reg, tap_next;
    logic [IR_W-1:0] ir_reg, ir_next, irs_reg, irs_next;
    logic [DR_W-1:0] drs_reg, drs_next;
    logic [DIV_W-1:0] div_reg, div_next, dcnt_reg, dcnt_next;
    logic [15:0] tick_reg, tick_next;
    logic busy_reg, busy_next, done_reg, done_next;
    logic tdo_reg, tdo_next, oe_reg, oe_next;
    logic sec_reg, sec_next, rel_reg, rel_next, init_reg, init_next;
    logic ce_reg, ce_next;
    logic tap_rst;
    logic trstn_sync;

    // TCK is only sampled, never used as a clock
    fslr_sync #(.W($bits(fslr_jtag_in_type))) u_sync (
        .mclk(mclk),
        .rstn(rstn),
        .d(jtag_in),
        .q(js)
    );

    // TAP reset pin is asynchronous too; held in reset until it settles
    fslr_sync #(.W(1)) u_sync_trst (
        .mclk(mclk),
        .rstn(rstn),
        .d(trstn),
        .q(trstn_sync)
    );

    assign tck_rise = js.tck & ~tck_d_reg;
    assign tck_fall = ~js.tck & tck_d_reg;
    assign tap_rst = ~trstn_sync;

    always_comb begin
        tck_d_next = js.tck;
        tap_next = tap_reg;
        ir_next = ir_reg;
        irs_next = irs_reg;
        drs_next = drs_reg;
        div_next = div_reg;
        tdo_next = tdo_reg;
        oe_next = oe_reg;
        if (tap_rst) begin
            tap_next = TS_RESET;
            ir_next = IR_IDCODE;
        end else if (tck_rise) begin
            unique case (tap_reg)
                TS_RESET: tap_next = js.tms ? TS_RESET : TS_IDLE;
                TS_IDLE: tap_next = js.tms ? TS_SEL_DR : TS_IDLE;
                TS_SEL_DR: tap_next = js.tms ? TS_SEL_IR : TS_CAP_DR;
                TS_CAP_DR: tap_next = js.tms ? TS_EX1_DR : TS_SH_DR;
                TS_SH_DR: tap_next = js.tms ? TS_EX1_DR : TS_SH_DR;
                TS_EX1_DR: tap_next = js.tms ? TS_UPD_DR : TS_PAU_DR;
                TS_PAU_DR: tap_next = js.tms ? TS_EX2_DR : TS_PAU_DR;
                TS_EX2_DR: tap_next = js.tms ? TS_UPD_DR : TS_SH_DR;
                TS_UPD_DR: tap_next = js.tms ? TS_SEL_DR : TS_IDLE;
                TS_SEL_IR: tap_next = js.tms ? TS_RESET : TS_CAP_IR;
                TS_CAP_IR: tap_next = js.tms ? TS_EX1_IR : TS_SH_IR;
                TS_SH_IR: tap_next = js.tms ? TS_EX1_IR : TS_SH_IR;
                TS_EX1_IR: tap_next = js.tms ? TS_UPD_IR : TS_PAU_IR;
                TS_PAU_IR: tap_next = js.tms ? TS_EX2_IR : TS_PAU_IR;
                TS_EX2_IR: tap_next = js.tms ? TS_UPD_IR : TS_SH_IR;
                TS_UPD_IR: tap_next = js.tms ? TS_SEL_DR : TS_IDLE;
            endcase
            unique case (tap_reg)
                TS_RESET: ir_next = IR_IDCODE;
                TS_CAP_IR: irs_next = IR_CAPTURE;
                TS_SH_IR: irs_next = {js.tdi, irs_reg[IR_W-1:1]};
                TS_UPD_IR: ir_next = irs_reg;
                TS_CAP_DR: begin
                    if (ir_reg == IR_IDCODE) begin
                        drs_next = IDCODE_VAL;
                    end else if (ir_reg == IR_RECOVER) begin
                        drs_next = DR_W'(div_reg);
                    end else if (ir_reg == IR_DEBUG && sec_reg) begin
                        drs_next = '0;
                    end else begin
                        drs_next = '0;
                    end
                end
                TS_SH_DR: begin
                    if (ir_reg == IR_RECOVER) begin
                        drs_next = {{(DR_W-DIV_W){1'b0}}, js.tdi,
                            drs_reg[DIV_W-1:1]};
                    end else if (ir_reg == IR_IDCODE) begin
                        drs_next = {js.tdi, drs_reg[DR_W-1:1]};
                    end else begin
                        drs_next = {{(DR_W-1){1'b0}}, js.tdi};
                    end
                end
                TS_UPD_DR: begin
                    if (ir_reg == IR_RECOVER && !busy_reg) begin
                        div_next = drs_reg[DIV_W-1:0];
                    end
                end
                default: ;
            endcase
        end
        // TDO changes on the falling edge, driven only while shifting
        if (tck_fall) begin
            oe_next = (tap_reg == TS_SH_DR) || (tap_reg == TS_SH_IR);
            tdo_next = (tap_reg == TS_SH_IR) ? irs_reg[0] : drs_reg[0];
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tck_d_reg <= 1'b0;
            tap_reg <= TS_RESET;
            ir_reg <= IR_IDCODE;
            irs_reg <= '0;
            drs_reg <= '0;
            div_reg <= DIV_RST;
            tdo_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            tck_d_reg <= tck_d_next;
            tap_reg <= tap_next;
            ir_reg <= ir_next;
            irs_reg <= irs_next;
            drs_reg <= drs_next;
            div_reg <= div_next;
            tdo_reg <= tdo_next;
            oe_reg <= oe_next;
        end
    end

    // Erase sequencer and security state
    always_comb begin
        busy_next = busy_reg;
        done_next = done_reg;
        dcnt_next = dcnt_reg;
        tick_next = tick_reg;
        ce_next = 1'b0;
        sec_next = sec_reg;
        rel_next = rel_reg;
        init_next = 1'b0;
        if (init_reg) begin
            // Strap sampled one clock after reset release
            sec_next = secure_strap;
        end
        if (!busy_reg && !done_reg && ir_reg == IR_RECOVER
            && tap_reg == TS_UPD_DR && tap_next == TS_IDLE) begin
            busy_next = 1'b1;
            // Divider lands on this same edge, so take the new value
            dcnt_next = div_next;
            tick_next = '0;
        end
        if (busy_reg) begin
            // Divider gives the erase timing strobe
            if (dcnt_reg == '0) begin
                dcnt_next = div_reg;
                ce_next = 1'b1;
                tick_next = tick_reg + 16'h0001;
                if (32'(tick_reg) == ERASE_TICKS_P - 1) begin
                    busy_next = 1'b0;
                    done_next = 1'b1;
                    rel_next = 1'b1;
                end
            end else begin
                dcnt_next = dcnt_reg - 7'h01;
            end
        end
        // Unlock word write, effective only after reset
        if (prog.req && prog.addr == UNLOCK_ADDR
            && prog.data == UNLOCK_WORD) begin
            rel_next = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            dcnt_reg <= '0;
            tick_reg <= '0;
            ce_reg <= 1'b0;
            sec_reg <= 1'b1;
            rel_reg <= 1'b0;
            init_reg <= 1'b1;
        end else begin
            busy_reg <= busy_next;
            done_reg <= done_next;
            dcnt_reg <= dcnt_next;
            tick_reg <= tick_next;
            ce_reg <= ce_next;
            sec_reg <= sec_next;
            rel_reg <= rel_next;
            init_reg <= init_next;
        end
    end

    // Security stays set until a device reset, even after erase
    assign secure = sec_reg;
    assign dbg_flash_grant = dbg_flash_req & ~sec_reg & ~busy_reg;
    assign flash_erase_busy = busy_reg;
    assign flash_erase_clk_en = ce_reg;
    assign flash_erase_done = done_reg;
    assign debug_sel = (ir_reg == IR_DEBUG);
    assign bscan_sel = (ir_reg == IR_EXTEST);
    assign tdo = tdo_reg;
    assign tdo_oe = oe_reg;
endmodule
`default_nettype wire

// ===== tb/fslr_chk.sv
// Port assertions for the recovery block
`timescale 1ns/10ps
`default_nettype none
module fslr_chk
    import fslr_pkg::*;
#(
    parameter int ERASE_TICKS_P = ERASE_TICKS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Request and watched outputs
    input wire logic dbg_flash_req,
    input wire logic dbg_flash_grant,
    input wire logic flash_erase_busy,
    input wire logic flash_erase_clk_en,
    input wire logic flash_erase_done,
    input wire logic secure
);
    // Full erases outlast any delay range, so they are counted instead
    logic [31:0] busy_cnt_reg, busy_cnt_next;
    logic [31:0] strobe_cnt_reg, strobe_cnt_next;
    always_comb begin
        busy_cnt_next = busy_cnt_reg + 32'(flash_erase_busy);
        strobe_cnt_next = strobe_cnt_reg + 32'(flash_erase_clk_en);
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            busy_cnt_reg <= '0;
            strobe_cnt_reg <= '0;
        end else begin
            busy_cnt_reg <= busy_cnt_next;
            strobe_cnt_reg <= strobe_cnt_next;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence go; $rose(flash_erase_busy); endsequence
    sequence stop; $fell(flash_erase_busy); endsequence
    chk_grant_gate: assert property (
        dbg_flash_grant == (dbg_flash_req && !secure && !flash_erase_busy))
        else $error("grant mismatch");
    chk_done_sticky: assert property (
        flash_erase_done |=> flash_erase_done) else $error("done fell");
    chk_done_late: assert property (
        $rose(flash_erase_done) |-> !flash_erase_busy) else $error("early");
    chk_end_done: assert property (
        stop |-> ##[0:1] flash_erase_done) else $error("no done");
    chk_erase_span: assert property (
        stop |-> busy_cnt_reg >= ERASE_TICKS_P) else $error("erase length");
    chk_strobe_count: assert property (
        $rose(flash_erase_done) |=> strobe_cnt_reg == ERASE_TICKS_P)
        else $error("strobe count");
    chk_strobe_gate: assert property (
        flash_erase_clk_en |-> flash_erase_busy || $past(flash_erase_busy))
        else $error("stray strobe");
    chk_lock_hold: assert property (
        !$stable(secure) |-> !$past(rstn, 4)) else $error("lock moved");
    chk_one_erase: assert property (
        flash_erase_done |-> not go) else $error("erase restarted");
endmodule
bind fslr_top fslr_chk #(.ERASE_TICKS_P(ERASE_TICKS_P)) fslr_chk_inst (
    .mclk, .rstn, .dbg_flash_req, .dbg_flash_grant, .flash_erase_busy,
    .flash_erase_clk_en, .flash_erase_done, .secure
);
`default_nettype wire

// ===== tb/fslr_host.sv
// Behavioural JTAG host driving the test pins
`timescale 1ns/10ps
`default_nettype none
module fslr_host
    import fslr_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Test pins
    output var fslr_jtag_in_type jtag,
    input wire logic tdo,
    input wire logic tdo_oe
);
    initial jtag = 3'h1;
    task automatic tick(input logic tms, input logic tdi, output logic td);
        @(negedge mclk);
        jtag = {1'h0, tms, tdi};
        repeat (3) @(negedge mclk);
        // A pin left undriven reads as zero
        td = tdo_oe ? tdo : 1'h0;
        jtag.tck = 1'h1;
        // Thirteen mclk per TCK, well under an eighth
        repeat (6) @(negedge mclk);
        // TCK idles low, matching the edge detector after reset
        jtag.tck = 1'h0;
        repeat (3) @(negedge mclk);
    endtask
    task automatic tap_reset();
        logic b;
        repeat (5) tick(1'h1, 1'h1, b);
        tick(1'h0, 1'h1, b);
    endtask
    task automatic shift(input logic ir, input int n, input logic [31:0] d,
                         output logic [31:0] q);
        logic b;
        q = '0;
        tick(1'h1, 1'h1, b);
        if (ir) tick(1'h1, 1'h1, b);
        repeat (2) tick(1'h0, 1'h1, b);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, d[i], b);
            q[i] = b;
        end
        tick(1'h1, 1'h1, b);
        tick(1'h0, 1'h1, b);
    endtask
endmodule
`default_nettype wire

// ===== tb/fslr_top_tb.sv
// Self-checking bench for the recovery block
`timescale 1ns/10ps
`default_nettype none
module fslr_top_tb;
    import fslr_pkg::*;
    localparam int TICKS = 8;
    logic mclk = 1'h0, rstn = 1'h0, trstn = 1'h0, secure_strap = 1'h1;
    logic dbg_flash_req = 1'h0, tdo, tdo_oe, dbg_flash_grant, secure;
    logic flash_erase_busy, flash_erase_clk_en, flash_erase_done;
    logic debug_sel, bscan_sel;
    logic [31:0] seed = 32'h0000_6a2b, q;
    logic [15:0] word;
    logic [6:0] dv;
    logic [3:0] codes [5] =
        '{IR_EXTEST, IR_CAPTURE, IR_IDCODE, IR_DEBUG, IR_BYPASS};
    int fail_count = 0, samples_checked = 0, cyc = 0, np = 0, t0, t1;
    int nb = 0;
    fslr_jtag_in_type jtag_in;
    fslr_prog_type prog = '0;
    fslr_top #(.ERASE_TICKS_P(TICKS)) fslr_top_inst (
        .mclk, .rstn, .jtag_in, .trstn, .tdo, .tdo_oe, .secure_strap, .prog,
        .dbg_flash_req, .dbg_flash_grant, .flash_erase_busy, .secure,
        .flash_erase_clk_en, .flash_erase_done, .debug_sel, .bscan_sel
    );
    fslr_host fslr_host_inst (.mclk, .jtag(jtag_in), .tdo, .tdo_oe);
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (flash_erase_busy === 1'h1) nb = nb + 1;
        if (flash_erase_clk_en === 1'h1) begin
            t0 = np == 0 ? cyc : t0;
            t1 = cyc;
            np = np + 1;
        end
        if (cyc == 20000) begin
            fail_count = fail_count + 1;
            end_sim();
        end
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic int exp_gap(input logic [6:0] d);
        return (TICKS - 1) * (int'(d) + 1);
    endfunction
    // Every strobe, the first included, is one divider period long
    function automatic int exp_len(input logic [6:0] d);
        return TICKS * (int'(d) + 1);
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED %0t got %0h want %0h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic do_reset(input logic s);
        @(negedge mclk);
        {rstn, trstn, secure_strap} = {2'h0, s};
        repeat (20) @(negedge mclk);
        {rstn, trstn} = 2'h3;
        repeat (3) @(negedge mclk);
        fslr_host_inst.tap_reset();
    endtask
    initial begin
        do_reset(1'h1);
        dbg_flash_req = 1'h1;
        @(negedge mclk);
        check(secure, 1'h1);
        check(dbg_flash_grant, 1'h0);
        $display("test lockout done");
        foreach (codes[i]) begin
            fslr_host_inst.shift(1'h1, IR_W, 32'(codes[i]), q);
            check(debug_sel, codes[i] === IR_DEBUG);
            check(bscan_sel, codes[i] === IR_EXTEST);
            check(tdo_oe, 1'h0);
        end
        fslr_host_inst.shift(1'h1, IR_W, 32'(IR_IDCODE), q);
        fslr_host_inst.shift(1'h0, IDCODE_W, rnd(), q);
        check(q, IDCODE_VAL);
        $display("test tap done");
        for (int k = 0; k < 2; k++) begin
            dv = k == 0 ? 7'h00 : 7'(rnd() & 32'h0000_003F);
            do_reset(1'h1);
            np = 0;
            nb = 0;
            fslr_host_inst.shift(1'h1, IR_W, 32'(IR_RECOVER), q);
            fslr_host_inst.shift(1'h0, DIV_W, 32'(dv), q);
            repeat (2000) if (flash_erase_done !== 1'h1) @(negedge mclk);
            check(flash_erase_done, 1'h1);
            // A second update after the erase must not start another
            fslr_host_inst.shift(1'h0, DIV_W, 32'(~dv), q);
            check(q, 32'(dv));
            check(flash_erase_busy, 1'h0);
            check(np, TICKS);
            check(t1 - t0, exp_gap(dv));
            check(nb, exp_len(dv));
            check(secure, 1'h1);
        end
        // Erased configuration reads unsecured at the next reset
        do_reset(1'h0);
        check(secure, 1'h0);
        check(dbg_flash_grant, 1'h1);
        $display("test erase done");
        for (int k = 0; k < 2; k++) begin
            do_reset(1'h1);
            word = k == 0 ? 16'(rnd() | 32'h0000_0001) : UNLOCK_WORD;
            prog = '{1'h1, UNLOCK_ADDR, word};
            @(negedge mclk);
            prog = '0;
            repeat (4) @(negedge mclk);
            check(secure, 1'h1);
            do_reset(word !== UNLOCK_WORD);
            check(secure, word !== UNLOCK_WORD);
        end
        $display("test unlock done");
        end_sim();
    end
endmodule
`default_nettype wire
